// >>> rtl/eiu_pkg.sv
// constants for the external pin interrupt unit
// assumes a plain byte register port with a two-bit word address
package eiu_pkg;

  // ==========================================================================
  // register addresses
  localparam logic [1:0] ADR_MCU_CTRL = 2'h0;
  localparam logic [1:0] ADR_MCU_CSR  = 2'h1;
  localparam logic [1:0] ADR_ENABLE   = 2'h2;
  localparam logic [1:0] ADR_FLAGS    = 2'h3;

  // ==========================================================================
  // field positions
  localparam int BIT_PIN2_EDGE = 6;
  localparam int BIT_EN_PIN1   = 7;
  localparam int BIT_EN_PIN0   = 6;
  localparam int BIT_EN_PIN2   = 5;
  localparam int BIT_PEND_PIN1 = 7;
  localparam int BIT_PEND_PIN0 = 6;
  localparam int BIT_PEND_PIN2 = 5;
  localparam int SENSE_W       = 2;

  // ==========================================================================
  // reset values
  localparam logic [3:0] RST_SENSE     = 4'h0;
  localparam logic       RST_PIN2_EDGE = 1'b0;
  localparam logic [2:0] RST_ENABLE    = 3'h0;
  localparam logic [2:0] RST_PENDING   = 3'h0;

  // ==========================================================================
  // sense encodings for pins 0 and 1
  typedef enum logic [1:0] {
    EIU_SENSE_LOW  = 2'h0,
    EIU_SENSE_ANY  = 2'h1,
    EIU_SENSE_FALL = 2'h2,
    EIU_SENSE_RISE = 2'h3
  } eiu_sense_t;

  // ==========================================================================
  // vector identities, one per pin
  localparam logic [1:0] VEC_NONE = 2'h0;
  localparam logic [1:0] VEC_PIN0 = 2'h1;
  localparam logic [1:0] VEC_PIN1 = 2'h2;
  localparam logic [1:0] VEC_PIN2 = 2'h3;

  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS       = 4;
  localparam int ASYNC_MIN_PULSE_NS  = 50;
  localparam int ASYNC_MIN_PULSE_CYC = (ASYNC_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// >>> rtl/eiu_sync.sv
// two flip-flop synchroniser, one lane per bit
// assumes inputs come from outside the core_clk domain
`timescale 1ns/1ps

module eiu_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  if (WIDTH < 1) begin : g_width_check
    $error("eiu_sync: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule // eiu_sync

// >>> rtl/eiu_top.sv
// external pin interrupt unit: three pins, enables, pending flags, requests
// assumes a single core_clk, cpu vector acknowledge pulses on core_clk
`timescale 1ns/1ps

module eiu_top (
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       pin0_in,
  input  wire logic       pin1_in,
  input  wire logic       pin2_in,
  input  wire logic       global_irq_en,
  input  wire logic       sleep_buf_off,
  input  wire logic [2:0] vec_ack,
  output logic      [2:0] irq_req,
  output logic      [1:0] irq_vector,
  output logic            irq
);

  // ==========================================================================
  // registers
  logic [3:0] ctrl_ff;
  logic       edge_sel_ff;
  logic [2:0] en_ff;
  logic [2:0] pend_ff;
  logic [7:0] rdata_ff;
  logic [1:0] vector_ff;
  logic [1:0] pin_prev_ff;
  logic       tog_prev_ff;
  logic       tog_ff;

  // ==========================================================================
  // register decode
  wire wr_ctrl   = reg_wr && (reg_addr == eiu_pkg::ADR_MCU_CTRL);
  wire wr_csr    = reg_wr && (reg_addr == eiu_pkg::ADR_MCU_CSR);
  wire wr_enable = reg_wr && (reg_addr == eiu_pkg::ADR_ENABLE);
  wire wr_flags  = reg_wr && (reg_addr == eiu_pkg::ADR_FLAGS);

  wire [2:0] w1c_mask = wr_flags ? {reg_wdata[eiu_pkg::BIT_PEND_PIN2],
                                    reg_wdata[eiu_pkg::BIT_PEND_PIN1],
                                    reg_wdata[eiu_pkg::BIT_PEND_PIN0]} : 3'h0;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_ff     <= eiu_pkg::RST_SENSE;
      edge_sel_ff <= eiu_pkg::RST_PIN2_EDGE;
      en_ff       <= eiu_pkg::RST_ENABLE;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= reg_wdata[3:0];
      end
      if (wr_csr) begin
        edge_sel_ff <= reg_wdata[eiu_pkg::BIT_PIN2_EDGE];
      end
      if (wr_enable) begin
        en_ff <= {reg_wdata[eiu_pkg::BIT_EN_PIN2],
                  reg_wdata[eiu_pkg::BIT_EN_PIN1],
                  reg_wdata[eiu_pkg::BIT_EN_PIN0]};
      end
    end
  end

  // ==========================================================================
  // pin2 asynchronous edge capture
  // buffer cut off in sleep while disabled forces the internal level low
  wire pin2_buf = pin2_in & ~(sleep_buf_off & ~en_ff[2]);
  // polarity change can itself make an edge: software must mask first
  wire pin2_edge_clk = pin2_buf ^ ~edge_sel_ff;

  always_ff @(posedge pin2_edge_clk or negedge arst_n) begin
    if (!arst_n) begin
      tog_ff <= 1'b0;
    end else begin
      tog_ff <= ~tog_ff;
    end
  end

  // ==========================================================================
  // synchronisers; pin inputs are read whatever the pad direction
  logic [2:0] sync_s;

  eiu_sync #(
    .WIDTH    (3)
  ) u_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .async_in ({tog_ff, pin1_in, pin0_in}),
    .sync_out (sync_s)
  );

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_prev_ff <= 2'h0;
      tog_prev_ff <= 1'b0;
    end else begin
      pin_prev_ff <= sync_s[1:0];
      tog_prev_ff <= sync_s[2];
    end
  end

  // ==========================================================================
  // sense decode for pins 0 and 1
  logic [2:0] set_evt;
  logic [1:0] level_mode;
  logic [1:0] level_low;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sense
      wire [1:0] sense = ctrl_ff[g*eiu_pkg::SENSE_W +: eiu_pkg::SENSE_W];
      wire       cur   = sync_s[g];
      wire       prev  = pin_prev_ff[g];
      wire       hit_any  = (sense == eiu_pkg::EIU_SENSE_ANY) && (cur ^ prev);
      wire       hit_fall = (sense == eiu_pkg::EIU_SENSE_FALL) && prev && !cur;
      wire       hit_rise = (sense == eiu_pkg::EIU_SENSE_RISE) && !prev && cur;
      assign set_evt[g]    = hit_any | hit_fall | hit_rise;
      assign level_mode[g] = (sense == eiu_pkg::EIU_SENSE_LOW);
      assign level_low[g]  = level_mode[g] && !cur;
    end
  endgenerate

  assign set_evt[2] = sync_s[2] ^ tog_prev_ff;

  // ==========================================================================
  // pending flags: set wins over clear, level mode holds them at zero
  wire [2:0] clr_mask = vec_ack | w1c_mask;
  wire [2:0] nxt_pend = ((pend_ff & ~clr_mask) | set_evt) & ~{1'b0, level_mode};

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_ff <= eiu_pkg::RST_PENDING;
    end else begin
      pend_ff <= nxt_pend;
    end
  end

  // ==========================================================================
  // requests and vector
  wire [2:0] req_src = {pend_ff[2],
                        level_mode[1] ? level_low[1] : pend_ff[1],
                        level_mode[0] ? level_low[0] : pend_ff[0]};

  assign irq_req = req_src & en_ff & {3{global_irq_en}};
  assign irq     = |irq_req;

  wire [1:0] nxt_vector = irq_req[0] ? eiu_pkg::VEC_PIN0 :
                          irq_req[1] ? eiu_pkg::VEC_PIN1 :
                          irq_req[2] ? eiu_pkg::VEC_PIN2 : eiu_pkg::VEC_NONE;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      vector_ff <= eiu_pkg::VEC_NONE;
    end else begin
      vector_ff <= nxt_vector;
    end
  end

  assign irq_vector = vector_ff;

  // ==========================================================================
  // read path, data in the cycle after the strobe only
  wire [7:0] rd_ctrl   = {4'h0, ctrl_ff};
  wire [7:0] rd_csr    = {1'b0, edge_sel_ff, 6'h00};
  wire [7:0] rd_enable = {en_ff[1], en_ff[0], en_ff[2], 5'h00};
  wire [7:0] rd_flags  = {pend_ff[1], pend_ff[0], pend_ff[2], 5'h00};
  wire [7:0] rd_mux    = (reg_addr == eiu_pkg::ADR_MCU_CTRL) ? rd_ctrl :
                         (reg_addr == eiu_pkg::ADR_MCU_CSR)  ? rd_csr :
                         (reg_addr == eiu_pkg::ADR_ENABLE)   ? rd_enable : rd_flags;
  wire [7:0] nxt_rdata = reg_rd ? rd_mux : 8'h00;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // ==========================================================================
  // assertions
  a_global_gates_req: assert property (@(posedge core_clk) disable iff (!arst_n)
    !global_irq_en |-> (irq_req == 3'h0))
    else $error("request raised with global enable low");

  a_pin2_event_sets: assert property (@(posedge core_clk) disable iff (!arst_n)
    (sync_s[2] != tog_prev_ff) |=> pend_ff[2])
    else $error("pin2 event did not set its flag");

  a_level_flag_zero: assert property (@(posedge core_clk) disable iff (!arst_n)
    level_mode[0] |=> !pend_ff[0])
    else $error("pin0 flag set in level mode");

  a_level_holds_req: assert property (@(posedge core_clk) disable iff (!arst_n)
    (level_mode[1] && !sync_s[1] && global_irq_en && en_ff[1]) |-> irq_req[1])
    else $error("pin1 low level not requesting");

  a_fall_sets_pin0: assert property (@(posedge core_clk) disable iff (!arst_n)
    (ctrl_ff[1:0] == eiu_pkg::EIU_SENSE_FALL && $fell(sync_s[0])) |=> pend_ff[0])
    else $error("pin0 falling edge missed");

  a_rise_sets_pin1: assert property (@(posedge core_clk) disable iff (!arst_n)
    (ctrl_ff[3:2] == eiu_pkg::EIU_SENSE_RISE && $rose(sync_s[1])) |=> pend_ff[1])
    else $error("pin1 rising edge missed");

  a_w1c_clears_pin2: assert property (@(posedge core_clk) disable iff (!arst_n)
    (wr_flags && reg_wdata[eiu_pkg::BIT_PEND_PIN2] && !set_evt[2]) |=> !pend_ff[2])
    else $error("pin2 flag survived write of one");

  a_vector_pin2: assert property (@(posedge core_clk) disable iff (!arst_n)
    (irq_req == 3'h4) |=> (irq_vector == eiu_pkg::VEC_PIN2))
    else $error("pin2 vector wrong");

  a_rdata_idle_zero: assert property (@(posedge core_clk) disable iff (!arst_n)
    !$past(reg_rd) |-> (reg_rdata == 8'h00))
    else $error("read data outside read slot");

  a_pin1_en_gates: assert property (@(posedge core_clk) disable iff (!arst_n)
    !en_ff[1] |-> !irq_req[1])
    else $error("pin1 request without its enable");

  a_pin0_en_gates: assert property (@(posedge core_clk) disable iff (!arst_n)
    !en_ff[0] |-> !irq_req[0])
    else $error("pin0 request without its enable");

  a_pin2_en_gates: assert property (@(posedge core_clk) disable iff (!arst_n)
    !en_ff[2] |-> !irq_req[2])
    else $error("pin2 request without its enable");

  a_pin2_flag_reqs: assert property (@(posedge core_clk) disable iff (!arst_n)
    (pend_ff[2] && en_ff[2] && global_irq_en) |-> irq_req[2])
    else $error("enabled pin2 flag not requesting");

  a_pin1_flag_reqs: assert property (@(posedge core_clk) disable iff (!arst_n)
    (!level_mode[1] && pend_ff[1] && en_ff[1] && global_irq_en) |-> irq_req[1])
    else $error("enabled pin1 flag not requesting");

  a_pin0_flag_reqs: assert property (@(posedge core_clk) disable iff (!arst_n)
    (!level_mode[0] && pend_ff[0] && en_ff[0] && global_irq_en) |-> irq_req[0])
    else $error("enabled pin0 flag not requesting");

  a_rise_sets_pin0: assert property (@(posedge core_clk) disable iff (!arst_n)
    (ctrl_ff[1:0] == eiu_pkg::EIU_SENSE_RISE && $rose(sync_s[0])) |=> pend_ff[0])
    else $error("pin0 rising edge missed");

  a_any_sets_pin0: assert property (@(posedge core_clk) disable iff (!arst_n)
    (ctrl_ff[1:0] == eiu_pkg::EIU_SENSE_ANY && $changed(sync_s[0])) |=> pend_ff[0])
    else $error("pin0 change missed");

  a_fall_sets_pin1: assert property (@(posedge core_clk) disable iff (!arst_n)
    (ctrl_ff[3:2] == eiu_pkg::EIU_SENSE_FALL && $fell(sync_s[1])) |=> pend_ff[1])
    else $error("pin1 falling edge missed");

  a_any_sets_pin1: assert property (@(posedge core_clk) disable iff (!arst_n)
    (ctrl_ff[3:2] == eiu_pkg::EIU_SENSE_ANY && $changed(sync_s[1])) |=> pend_ff[1])
    else $error("pin1 change missed");

  a_rise_only_pin0: assert property (@(posedge core_clk) disable iff (!arst_n)
    (ctrl_ff[1:0] == eiu_pkg::EIU_SENSE_RISE && !$rose(sync_s[0]) && !pend_ff[0])
    |=> !pend_ff[0])
    else $error("pin0 flag set without rising edge");

  a_fall_only_pin1: assert property (@(posedge core_clk) disable iff (!arst_n)
    (ctrl_ff[3:2] == eiu_pkg::EIU_SENSE_FALL && !$fell(sync_s[1]) && !pend_ff[1])
    |=> !pend_ff[1])
    else $error("pin1 flag set without falling edge");

  a_level_flag_zero1: assert property (@(posedge core_clk) disable iff (!arst_n)
    level_mode[1] |=> !pend_ff[1])
    else $error("pin1 flag set in level mode");

  a_level_req_pin0: assert property (@(posedge core_clk) disable iff (!arst_n)
    (level_mode[0] && !sync_s[0] && global_irq_en && en_ff[0]) |-> irq_req[0])
    else $error("pin0 low level not requesting");

  a_level_quiet_pin0: assert property (@(posedge core_clk) disable iff (!arst_n)
    (level_mode[0] && sync_s[0]) |-> !irq_req[0])
    else $error("pin0 high level requesting");

  a_level_quiet_pin1: assert property (@(posedge core_clk) disable iff (!arst_n)
    (level_mode[1] && sync_s[1]) |-> !irq_req[1])
    else $error("pin1 high level requesting");

  a_ack_clears_pin0: assert property (@(posedge core_clk) disable iff (!arst_n)
    (vec_ack[0] && !set_evt[0]) |=> !pend_ff[0])
    else $error("pin0 flag survived its routine");

  a_ack_clears_pin1: assert property (@(posedge core_clk) disable iff (!arst_n)
    (vec_ack[1] && !set_evt[1]) |=> !pend_ff[1])
    else $error("pin1 flag survived its routine");

  a_ack_clears_pin2: assert property (@(posedge core_clk) disable iff (!arst_n)
    (vec_ack[2] && !set_evt[2]) |=> !pend_ff[2])
    else $error("pin2 flag survived its routine");

  a_w1c_clears_pin0: assert property (@(posedge core_clk) disable iff (!arst_n)
    (wr_flags && reg_wdata[eiu_pkg::BIT_PEND_PIN0] && !set_evt[0]) |=> !pend_ff[0])
    else $error("pin0 flag survived write of one");

  a_pin2_flag_sticks: assert property (@(posedge core_clk) disable iff (!arst_n)
    (pend_ff[2] && !vec_ack[2] && !w1c_mask[2]) |=> pend_ff[2])
    else $error("pin2 flag lost without a clear");

  a_pin2_no_event: assert property (@(posedge core_clk) disable iff (!arst_n)
    (sync_s[2] == tog_prev_ff && !pend_ff[2]) |=> !pend_ff[2])
    else $error("pin2 flag set without an event");

  a_vector_pin0: assert property (@(posedge core_clk) disable iff (!arst_n)
    irq_req[0] |=> (irq_vector == eiu_pkg::VEC_PIN0))
    else $error("pin0 vector wrong");

  a_vector_pin1: assert property (@(posedge core_clk) disable iff (!arst_n)
    (irq_req[1] && !irq_req[0]) |=> (irq_vector == eiu_pkg::VEC_PIN1))
    else $error("pin1 vector wrong");

  a_vector_none: assert property (@(posedge core_clk) disable iff (!arst_n)
    (irq_req == 3'h0) |=> (irq_vector == eiu_pkg::VEC_NONE))
    else $error("vector shown without a request");

  a_sense_write: assert property (@(posedge core_clk) disable iff (!arst_n)
    wr_ctrl |=> (ctrl_ff == $past(reg_wdata[3:0])))
    else $error("sense fields not written");

  a_edge_sel_write: assert property (@(posedge core_clk) disable iff (!arst_n)
    wr_csr |=> (edge_sel_ff == $past(reg_wdata[eiu_pkg::BIT_PIN2_EDGE])))
    else $error("pin2 edge select not written");

  a_enable_write: assert property (@(posedge core_clk) disable iff (!arst_n)
    wr_enable |=> (en_ff[1] == $past(reg_wdata[eiu_pkg::BIT_EN_PIN1])))
    else $error("pin1 enable not written");

endmodule // eiu_top

// >>> dv/eiu_cpu_model.sv
// partner model: cpu vectoring side, acknowledges the vector it is shown
// assumes vector ids 1..3 stand for vec_ack bits 0..2
`timescale 1ns/1ps

module eiu_cpu_model (
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  input  wire logic       ack_en,
  input  wire logic [3:0] ack_dly,
  input  wire logic [1:0] irq_vector,
  output logic      [2:0] vec_ack
);
  logic [3:0] wait_ff;
  logic       hold_ff;

  // ==========================================================================
  // one acknowledge pulse after ack_dly cycles, then rearm
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_ff <= 4'h0;
      vec_ack <= 3'h0;
      hold_ff <= 1'b0;
    end else begin
      vec_ack <= 3'h0;
      // the vector lags an acknowledge by two edges: never ack a stale one
      hold_ff <= (vec_ack != 3'h0);
      if (!ack_en || irq_vector == eiu_pkg::VEC_NONE || vec_ack != 3'h0 || hold_ff) begin
        wait_ff <= 4'h0;
      end else if (wait_ff >= ack_dly) begin
        vec_ack <= 3'h1 << (irq_vector - 2'h1);
        wait_ff <= 4'h0;
      end else begin
        wait_ff <= wait_ff + 4'h1;
      end
    end
  end
endmodule // eiu_cpu_model

// >>> dv/eiu_top_tb_top.sv
// testbench for the external pin interrupt unit
// assumes the cpu model acknowledges vectors when ack_en is high
`timescale 1ns/1ps

module eiu_top_tb_top;
  logic       core_clk, arst_n, reg_wr, reg_rd, rd_d_ff, pin0_in, pin1_in, pin2_in;
  logic       global_irq_en, sleep_buf_off, ack_en, irq;
  logic [1:0] reg_addr, irq_vector;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic [2:0] vec_ack, irq_req;
  logic [3:0] ack_dly;
  logic [7:0] exp_q[$];
  int         err_total, checks_done, cyc;

  eiu_top dut_u (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pin0_in(pin0_in), .pin1_in(pin1_in), .pin2_in(pin2_in),
    .global_irq_en(global_irq_en), .sleep_buf_off(sleep_buf_off), .vec_ack(vec_ack),
    .irq_req(irq_req), .irq_vector(irq_vector), .irq(irq));
  eiu_cpu_model cpu_u (.core_clk(core_clk), .arst_n(arst_n), .ack_en(ack_en),
    .ack_dly(ack_dly), .irq_vector(irq_vector), .vec_ack(vec_ack));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
    @(posedge core_clk); reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    reg_addr <= a; reg_rd <= 1'b1; exp_q.push_back(e);
    @(posedge core_clk); reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic pin_set(input int p, input logic v);
    if (p == 0) pin0_in <= v;
    else if (p == 1) pin1_in <= v;
    else pin2_in <= v;
    repeat (16) @(posedge core_clk);
  endtask

  // ==========================================================================
  // read data stand in the cycle after the strobe; oldest note is compared
  always @(posedge core_clk) begin
    rd_d_ff <= reg_rd;
    if (rd_d_ff && exp_q.size() > 0) chk(reg_rdata, exp_q.pop_front());
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      report_and_stop();
    end
  end

  initial begin
    {arst_n, reg_wr, reg_rd, global_irq_en, sleep_buf_off, ack_en} = 6'h0;
    {pin0_in, pin1_in, pin2_in} = 3'h7;
    reg_addr = 2'h0; reg_wdata = 8'h00; ack_dly = 4'h0;
    void'($urandom(73546));
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    for (int a = 0; a < 4; a++) rd(2'(a), 8'h00);
    wr(eiu_pkg::ADR_MCU_CTRL, 8'hff); rd(eiu_pkg::ADR_MCU_CTRL, 8'h0f);
    d = 8'($urandom); wr(eiu_pkg::ADR_MCU_CSR, d); rd(eiu_pkg::ADR_MCU_CSR, d & 8'h40);
    wr(eiu_pkg::ADR_ENABLE, 8'hff); rd(eiu_pkg::ADR_ENABLE, 8'he0);
    wr(eiu_pkg::ADR_ENABLE, 8'h00);
    // every edge code on pins 0 and 1
    for (int p = 0; p < 2; p++) for (int c = 1; c < 4; c++) begin
      wr(eiu_pkg::ADR_MCU_CTRL, 8'(c << (2 * p))); wr(eiu_pkg::ADR_FLAGS, 8'hff);
      pin_set(p, 1'b0); rd(eiu_pkg::ADR_FLAGS, (c != 3) ? 8'(8'h40 << p) : 8'h00);
      wr(eiu_pkg::ADR_FLAGS, 8'hff);
      pin_set(p, 1'b1); rd(eiu_pkg::ADR_FLAGS, (c != 2) ? 8'(8'h40 << p) : 8'h00);
    end
    // low level on pin 0
    wr(eiu_pkg::ADR_MCU_CTRL, 8'h00); wr(eiu_pkg::ADR_ENABLE, 8'he0); global_irq_en <= 1'b1;
    pin_set(0, 1'b0); chk({5'h0, irq_req}, 8'h01);
    rd(eiu_pkg::ADR_FLAGS, 8'h00);
    global_irq_en <= 1'b0; repeat (2) @(posedge core_clk);
    chk({7'h0, irq}, 8'h00);
    pin_set(0, 1'b1); wr(eiu_pkg::ADR_ENABLE, 8'h00);
    // pin 2 falling, then rising select
    wr(eiu_pkg::ADR_MCU_CSR, 8'h00); wr(eiu_pkg::ADR_FLAGS, 8'hff);
    pin_set(2, 1'b0); rd(eiu_pkg::ADR_FLAGS, 8'h20);
    wr(eiu_pkg::ADR_FLAGS, 8'h00); rd(eiu_pkg::ADR_FLAGS, 8'h20);
    wr(eiu_pkg::ADR_FLAGS, 8'h20); pin_set(2, 1'b1); rd(eiu_pkg::ADR_FLAGS, 8'h00);
    wr(eiu_pkg::ADR_MCU_CSR, 8'h40); repeat (4) @(posedge core_clk);
    wr(eiu_pkg::ADR_FLAGS, 8'hff); rd(eiu_pkg::ADR_FLAGS, 8'h00);
    pin_set(2, 1'b0); pin_set(2, 1'b1); rd(eiu_pkg::ADR_FLAGS, 8'h20);
    // a pulse just above the minimum width is still caught
    wr(eiu_pkg::ADR_FLAGS, 8'h20);
    pin2_in <= 1'b0;
    repeat (eiu_pkg::ASYNC_MIN_PULSE_CYC) @(posedge core_clk);
    pin2_in <= 1'b1;
    repeat (8) @(posedge core_clk);
    rd(eiu_pkg::ADR_FLAGS, 8'h20);
    // vector of pin 2, then acknowledge
    global_irq_en <= 1'b1; wr(eiu_pkg::ADR_ENABLE, 8'h20); @(posedge core_clk);
    chk({2'h0, irq, irq_vector, irq_req}, {2'h0, 1'b1, eiu_pkg::VEC_PIN2, 3'h4});
    ack_dly <= 4'($urandom_range(0, 7)); ack_en <= 1'b1;
    repeat (14) @(posedge core_clk);
    rd(eiu_pkg::ADR_FLAGS, 8'h00); chk({7'h0, irq}, 8'h00);
    // pins 0 and 1 together, pin 0 wins the vector
    ack_en <= 1'b0; wr(eiu_pkg::ADR_MCU_CTRL, 8'h0a); wr(eiu_pkg::ADR_FLAGS, 8'hff);
    wr(eiu_pkg::ADR_ENABLE, 8'he0); pin0_in <= 1'b0; pin1_in <= 1'b0;
    repeat (8) @(posedge core_clk);
    chk({3'h0, irq_vector, irq_req}, {3'h0, eiu_pkg::VEC_PIN0, 3'h3});
    rd(eiu_pkg::ADR_FLAGS, 8'hc0); ack_en <= 1'b1;
    repeat (30) @(posedge core_clk);
    rd(eiu_pkg::ADR_FLAGS, 8'h00);
    // sleep cuts the pin 2 buffer while disabled
    ack_en <= 1'b0; wr(eiu_pkg::ADR_ENABLE, 8'h00); wr(eiu_pkg::ADR_MCU_CSR, 8'h00);
    wr(eiu_pkg::ADR_FLAGS, 8'hff); sleep_buf_off <= 1'b1;
    repeat (8) @(posedge core_clk);
    rd(eiu_pkg::ADR_FLAGS, 8'h20);
    // reset in mid-run returns every register to zero
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    for (int a = 0; a < 4; a++) rd(2'(a), 8'h00);
    report_and_stop();
  end
endmodule // eiu_top_tb_top
